// *** src/fcs_pkg.sv ***
// Shared constants and types for the shift-keying coefficient sequencer.
// Assumes a single 40 MHz clock and word-wide register access over AHB-Lite.
`default_nettype none

package fcs_pkg;

  // ===========================================================================
  // Clocking and the sample-rate enable.
  // ===========================================================================
  localparam int unsigned CLK_HZ     = 40_000_000;
  localparam int unsigned SAMPLE_HZ  = 16_000;
  localparam int unsigned SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;

  // ===========================================================================
  // Register indices. Byte address is four times the index.
  // ===========================================================================
  localparam logic [7:0] IDX_RELOAD_CTRL = 8'h20;
  localparam logic [7:0] IDX_SPACE_AMP   = 8'h45;
  localparam logic [7:0] IDX_SPACE_FREQ  = 8'h46;
  localparam logic [7:0] IDX_MARK_AMP    = 8'h47;
  localparam logic [7:0] IDX_MARK_FREQ   = 8'h48;
  localparam logic [7:0] IDX_S2M_GAIN    = 8'h49;
  localparam logic [7:0] IDX_M2S_GAIN    = 8'h4A;
  localparam logic [7:0] IDX_TONE_AMP    = 8'h50;
  localparam logic [7:0] IDX_TONE_FREQ   = 8'h51;
  localparam logic [7:0] IDX_ACT_TIMER   = 8'h52;
  localparam logic [7:0] IDX_TX_BIT      = 8'h53;
  localparam logic [7:0] IDX_STATUS      = 8'h54;
  localparam logic [7:0] IDX_MODE_CTRL   = 8'h6C;

  // ===========================================================================
  // Field positions, widths and values after reset.
  // ===========================================================================
  localparam int unsigned COEF_W         = 16;
  localparam int unsigned CTRL_W         = 8;
  localparam int unsigned GAIN_FRAC      = 14;
  localparam int unsigned BIT_OSC_EN     = 0;
  localparam int unsigned BIT_RELOAD_EN  = 6;
  localparam int unsigned BIT_MODE_EN    = 6;
  localparam int unsigned BIT_TX_BIT     = 0;
  localparam int unsigned ST_BIT_RUN     = 0;
  localparam int unsigned ST_BIT_ENH     = 1;
  localparam int unsigned ST_BIT_LASTBIT = 2;
  localparam int unsigned ST_BIT_COUNT   = 16;
  localparam logic [15:0] COEF_RESET     = 16'h0000;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [15:0] TIMER_RESET    = 16'h0001;

  // ===========================================================================
  // Bus encodings and sequencer states.
  // ===========================================================================
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD    = 3'b010;
  localparam logic       HRESP_OKAY    = 1'b0;

  typedef enum logic [1:0] {
    FCS_ST_IDLE = 2'b01,
    FCS_ST_RUN  = 2'b10
  } fcs_state_t;

endpackage

`default_nettype wire

// *** src/fcs_gain_scale.sv ***
// Signed coefficient times signed gain, rescaled and saturated.
// Assumes the gain carries FRAC fraction bits; purely combinational.
`default_nettype none

module fcs_gain_scale #(
  parameter int unsigned W    = 16,
  parameter int unsigned FRAC = 14
) (
  input  wire logic [W-1:0] coef,
  input  wire logic [W-1:0] gain,
  output logic      [W-1:0] scaled
);

  localparam logic signed [2*W-1:0] MAX_V = {{(W+1){1'b0}}, {(W-1){1'b1}}};
  localparam logic signed [2*W-1:0] MIN_V = {{(W+1){1'b1}}, {(W-1){1'b0}}};

  logic signed [2*W-1:0] prod;
  logic signed [2*W-1:0] shifted;

  // Both operands are two's complement, so the product is signed.
  assign prod    = $signed(coef) * $signed(gain);
  assign shifted = prod >>> FRAC;

  // Saturate rather than wrap: a wrapped amplitude flips the tone's sign.
  always_comb begin
    if (shifted > MAX_V) begin
      scaled = MAX_V[W-1:0];
    end else if (shifted < MIN_V) begin
      scaled = MIN_V[W-1:0];
    end else begin
      scaled = shifted[W-1:0];
    end
  end

endmodule

`default_nettype wire

// *** src/fcs_active_timer.sv ***
// Active timer of the first tone oscillator, counting sample ticks.
// Assumes tick is a one-cycle enable at the sample rate.
`default_nettype none

module fcs_active_timer #(
  parameter int unsigned W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         run,
  input  wire logic         tick,
  input  wire logic [W-1:0] period,
  output logic              expire_r,
  output logic      [W-1:0] count_r
);

  localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

  // A period of zero behaves as one tick so the timer never stalls.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_r  <= '0;
      expire_r <= 1'b0;
    end else if (!run) begin
      count_r  <= period;
      expire_r <= 1'b0;
    end else if (tick) begin
      if (count_r <= ONE) begin
        count_r  <= period;
        expire_r <= 1'b1;
      end else begin
        count_r  <= count_r - ONE;
        expire_r <= 1'b0;
      end
    end else begin
      expire_r <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// *** src/fcs_sequencer.sv ***
// Shift-keying coefficient sequencer for tone oscillator one, with AHB-Lite registers.
// Assumes one 40 MHz clock, a single AHB-Lite master doing word transfers,
// and an oscillator downstream that takes amplitude and frequency on a load pulse.
//
// Functional notes
// - Enhanced mode only when mode enable and reload enable, both bit six, are set.
// - Space on timer expiry loads the space amplitude instead of the normal one.
// - Space on timer expiry loads the space frequency instead of the normal one.
// - Mark on timer expiry loads the mark amplitude instead of the normal one.
// - Mark on timer expiry loads the mark frequency instead of the normal one.
// - A space to mark change scales amplitude by the space-to-mark gain.
// - A mark to space change scales amplitude by the mark-to-space gain.
// - Every coefficient is treated as a two's-complement signed value.
`default_nettype none

module fcs_sequencer (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic      [31:0]               hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic      [fcs_pkg::COEF_W-1:0] osc_amp,
  output logic      [fcs_pkg::COEF_W-1:0] osc_freq,
  output logic                           osc_load,
  output logic                           osc_running
);

  import fcs_pkg::*;

  // ===========================================================================
  // Register storage.
  // ===========================================================================
  logic [CTRL_W-1:0] reload_ctrl_r;
  logic [CTRL_W-1:0] mode_ctrl_r;
  logic [COEF_W-1:0] space_amplitude_coef_r;
  logic [COEF_W-1:0] space_frequency_coef_r;
  logic [COEF_W-1:0] mark_amplitude_coef_r;
  logic [COEF_W-1:0] mark_frequency_coef_r;
  logic [COEF_W-1:0] space_to_mark_gain_r;
  logic [COEF_W-1:0] mark_to_space_gain_r;
  logic [COEF_W-1:0] tone_gen_one_amplitude_coef_r;
  logic [COEF_W-1:0] tone_gen_one_frequency_coef_r;
  logic [COEF_W-1:0] tone_gen_one_active_timer_r;
  logic              tx_bit_r;

  // ===========================================================================
  // Sequencer state.
  // ===========================================================================
  fcs_state_t        state_r;
  fcs_state_t        state_nxt;
  logic              last_bit_r;
  logic              have_bit_r;
  logic [31:0]       div_cnt_r;
  logic              tick_r;
  logic              timer_expire;
  logic [COEF_W-1:0] timer_count;
  logic [COEF_W-1:0] gain_sel;
  logic [COEF_W-1:0] amp_sel;
  logic [COEF_W-1:0] amp_scaled;
  logic              shift_keying_mode_enable;
  logic              oscillator_reload_enable;
  logic              enhanced;
  logic              bit_change;
  logic              osc_enable;

  // ===========================================================================
  // Bus slave: address phase capture.
  // ===========================================================================
  logic        addr_ok;
  logic        wr_pend_r;
  logic [7:0]  wr_idx_r;
  logic [7:0]  idx;
  logic [31:0] rd_mux;

  assign idx     = haddr[9:2];
  assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ) && (haddr[31:10] == 22'h000000);

  // Writes land in the data phase, one cycle after the address phase.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 8'h00;
    end else if (hready) begin
      wr_pend_r <= addr_ok && hwrite && (hsize == HSIZE_WORD);
      wr_idx_r  <= idx;
    end
  end

  // The slave never inserts wait states and never signals an error.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end
  end

  // ===========================================================================
  // Read decode. Unmapped indices and unused bits read as zero.
  // ===========================================================================
  always_comb begin
    rd_mux = 32'h00000000;
    unique case (idx)
      IDX_RELOAD_CTRL: rd_mux[CTRL_W-1:0] = reload_ctrl_r;
      IDX_MODE_CTRL:   rd_mux[CTRL_W-1:0] = mode_ctrl_r;
      IDX_SPACE_AMP:   rd_mux[COEF_W-1:0] = space_amplitude_coef_r;
      IDX_SPACE_FREQ:  rd_mux[COEF_W-1:0] = space_frequency_coef_r;
      IDX_MARK_AMP:    rd_mux[COEF_W-1:0] = mark_amplitude_coef_r;
      IDX_MARK_FREQ:   rd_mux[COEF_W-1:0] = mark_frequency_coef_r;
      IDX_S2M_GAIN:    rd_mux[COEF_W-1:0] = space_to_mark_gain_r;
      IDX_M2S_GAIN:    rd_mux[COEF_W-1:0] = mark_to_space_gain_r;
      IDX_TONE_AMP:    rd_mux[COEF_W-1:0] = tone_gen_one_amplitude_coef_r;
      IDX_TONE_FREQ:   rd_mux[COEF_W-1:0] = tone_gen_one_frequency_coef_r;
      IDX_ACT_TIMER:   rd_mux[COEF_W-1:0] = tone_gen_one_active_timer_r;
      IDX_TX_BIT:      rd_mux[BIT_TX_BIT] = tx_bit_r;
      IDX_STATUS: begin
        rd_mux[ST_BIT_RUN]                        = (state_r == FCS_ST_RUN);
        rd_mux[ST_BIT_ENH]                        = enhanced;
        rd_mux[ST_BIT_LASTBIT]                    = last_bit_r;
        rd_mux[ST_BIT_COUNT+COEF_W-1:ST_BIT_COUNT] = timer_count;
      end
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Read data is sampled at the address phase so it stands in the data phase.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

  // ===========================================================================
  // Control register writes.
  // ===========================================================================
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reload_ctrl_r <= CTRL_RESET;
      mode_ctrl_r   <= CTRL_RESET;
      tx_bit_r      <= 1'b0;
    end else if (wr_pend_r) begin
      if (wr_idx_r == IDX_RELOAD_CTRL) begin
        reload_ctrl_r <= hwdata[CTRL_W-1:0];
      end
      if (wr_idx_r == IDX_MODE_CTRL) begin
        mode_ctrl_r <= hwdata[CTRL_W-1:0];
      end
      if (wr_idx_r == IDX_TX_BIT) begin
        tx_bit_r <= hwdata[BIT_TX_BIT];
      end
    end
  end

  // ===========================================================================
  // Coefficient register writes.
  // ===========================================================================
  // Coefficients are cleared at reset only for a known simulation start;
  // software must still program them before arming the enhanced mode.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      space_amplitude_coef_r <= COEF_RESET;
      space_frequency_coef_r <= COEF_RESET;
      mark_amplitude_coef_r  <= COEF_RESET;
      mark_frequency_coef_r  <= COEF_RESET;
      space_to_mark_gain_r   <= COEF_RESET;
      mark_to_space_gain_r   <= COEF_RESET;
    end else if (wr_pend_r) begin
      unique case (wr_idx_r)
        IDX_SPACE_AMP:  space_amplitude_coef_r <= hwdata[COEF_W-1:0];
        IDX_SPACE_FREQ: space_frequency_coef_r <= hwdata[COEF_W-1:0];
        IDX_MARK_AMP:   mark_amplitude_coef_r  <= hwdata[COEF_W-1:0];
        IDX_MARK_FREQ:  mark_frequency_coef_r  <= hwdata[COEF_W-1:0];
        IDX_S2M_GAIN:   space_to_mark_gain_r   <= hwdata[COEF_W-1:0];
        IDX_M2S_GAIN:   mark_to_space_gain_r   <= hwdata[COEF_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // ===========================================================================
  // Ordinary oscillator register writes.
  // ===========================================================================
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tone_gen_one_amplitude_coef_r <= COEF_RESET;
      tone_gen_one_frequency_coef_r <= COEF_RESET;
      tone_gen_one_active_timer_r   <= TIMER_RESET;
    end else if (wr_pend_r) begin
      unique case (wr_idx_r)
        IDX_TONE_AMP:  tone_gen_one_amplitude_coef_r <= hwdata[COEF_W-1:0];
        IDX_TONE_FREQ: tone_gen_one_frequency_coef_r <= hwdata[COEF_W-1:0];
        IDX_ACT_TIMER: tone_gen_one_active_timer_r   <= hwdata[COEF_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // ===========================================================================
  // Sample-rate enable.
  // ===========================================================================
  localparam logic [31:0] DIV_LAST = 32'(SAMPLE_DIV - 1);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_cnt_r <= 32'h00000000;
      tick_r    <= 1'b0;
    end else if (div_cnt_r == DIV_LAST) begin
      div_cnt_r <= 32'h00000000;
      tick_r    <= 1'b1;
    end else begin
      div_cnt_r <= div_cnt_r + 32'h00000001;
      tick_r    <= 1'b0;
    end
  end

  // ===========================================================================
  // Mode decode.
  // ===========================================================================
  assign shift_keying_mode_enable = mode_ctrl_r[BIT_MODE_EN];
  assign oscillator_reload_enable = reload_ctrl_r[BIT_RELOAD_EN];
  assign osc_enable               = reload_ctrl_r[BIT_OSC_EN];
  assign enhanced                 = shift_keying_mode_enable && oscillator_reload_enable;

  // The first load after arming counts as no transition, since no bit precedes it.
  assign bit_change = have_bit_r && (tx_bit_r != last_bit_r);

  // ===========================================================================
  // Oscillator run state.
  // ===========================================================================
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      FCS_ST_IDLE: if (osc_enable) state_nxt = FCS_ST_RUN;
      FCS_ST_RUN:  if (!osc_enable) state_nxt = FCS_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= FCS_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  fcs_active_timer #(
    .W (COEF_W)
  ) u_timer (
    .clk      (clk),
    .rst_n    (rst_n),
    .run      (state_r == FCS_ST_RUN),
    .tick     (tick_r),
    .period   (tone_gen_one_active_timer_r),
    .expire_r (timer_expire),
    .count_r  (timer_count)
  );

  // ===========================================================================
  // Coefficient selection on timer expiry.
  // ===========================================================================
  always_comb begin
    amp_sel  = tone_gen_one_amplitude_coef_r;
    gain_sel = mark_to_space_gain_r;
    if (enhanced) begin
      if (tx_bit_r) begin
        amp_sel  = mark_amplitude_coef_r;
        gain_sel = space_to_mark_gain_r;
      end else begin
        amp_sel  = space_amplitude_coef_r;
        gain_sel = mark_to_space_gain_r;
      end
    end
  end

  fcs_gain_scale #(
    .W    (COEF_W),
    .FRAC (GAIN_FRAC)
  ) u_gain (
    .coef   (amp_sel),
    .gain   (gain_sel),
    .scaled (amp_scaled)
  );

  // ===========================================================================
  // Oscillator reload.
  // ===========================================================================
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osc_amp  <= COEF_RESET;
      osc_freq <= COEF_RESET;
      osc_load <= 1'b0;
    end else if (timer_expire && (state_r == FCS_ST_RUN)) begin
      osc_load <= 1'b1;
      if (!enhanced) begin
        osc_amp  <= tone_gen_one_amplitude_coef_r;
        osc_freq <= tone_gen_one_frequency_coef_r;
      end else begin
        osc_amp  <= bit_change ? amp_scaled : amp_sel;
        osc_freq <= tx_bit_r ? mark_frequency_coef_r : space_frequency_coef_r;
      end
    end else begin
      osc_load <= 1'b0;
    end
  end

  // The previous bit is forgotten when the mode is left, so re-arming starts clean.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      last_bit_r <= 1'b0;
      have_bit_r <= 1'b0;
    end else if (!enhanced || (state_r != FCS_ST_RUN)) begin
      have_bit_r <= 1'b0;
    end else if (timer_expire) begin
      last_bit_r <= tx_bit_r;
      have_bit_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osc_running <= 1'b0;
    end else begin
      osc_running <= (state_nxt == FCS_ST_RUN);
    end
  end

endmodule

`default_nettype wire

// *** bench/fcs_sequencer_asserts.sv ***
// Concurrent checks for the shift-keying sequencer, seeing only its ports.
// Assumes zero-wait AHB-Lite word writes and a shadow of the registers kept here from bus traffic.
`default_nettype none

module fcs_sequencer_asserts (
  input wire logic                       clk,
  input wire logic                       rst_n,
  input wire logic                       hsel,
  input wire logic [31:0]                haddr,
  input wire logic [1:0]                 htrans,
  input wire logic                       hwrite,
  input wire logic [2:0]                 hsize,
  input wire logic [31:0]                hwdata,
  input wire logic                       hready,
  input wire logic [31:0]                hrdata,
  input wire logic                       hreadyout,
  input wire logic                       hresp,
  input wire logic [fcs_pkg::COEF_W-1:0] osc_amp,
  input wire logic [fcs_pkg::COEF_W-1:0] osc_freq,
  input wire logic                       osc_load,
  input wire logic                       osc_running
);
  import fcs_pkg::*;

  // ===========================================================================
  // Register shadow built from observed write data phases.
  // ===========================================================================
  logic [15:0] sh [0:255];
  logic        ap_v;
  logic        ap_wr;
  logic [7:0]  ap_idx;
  logic        rd_st;
  logic        st_exp;
  logic        lb_v;
  logic        lb;
  logic        enh;
  logic        txb;
  logic        take;

  assign take = hsel && hready && htrans == HTRANS_NONSEQ && haddr[31:10] == 22'h0;
  assign enh  = sh[IDX_MODE_CTRL][BIT_MODE_EN] && sh[IDX_RELOAD_CTRL][BIT_RELOAD_EN];
  assign txb  = sh[IDX_TX_BIT][BIT_TX_BIT];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 256; i++) sh[i] <= 16'h0000;
      ap_v  <= 1'b0;
      rd_st <= 1'b0;
    end else begin
      ap_v   <= take;
      ap_wr  <= hwrite && hsize == HSIZE_WORD;
      ap_idx <= haddr[9:2];
      rd_st  <= take && !hwrite && haddr[9:2] == IDX_STATUS;
      st_exp <= enh;
      if (ap_v && ap_wr) sh[ap_idx] <= hwdata[15:0];
    end
  end

  // The previous load decides whether a bit change is a real transition.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lb_v <= 1'b0;
      lb   <= 1'b0;
    end else if (osc_load) begin
      lb_v <= enh;
      lb   <= txb;
    end
  end

  function automatic logic [15:0] scl(input logic [15:0] c, input logic [15:0] g);
    logic signed [31:0] p;
    p = ($signed(c) * $signed(g)) >>> GAIN_FRAC;
    if (p > 32767) return 16'h7FFF;
    if (p < -32768) return 16'h8000;
    return p[15:0];
  endfunction

  // ===========================================================================
  // Assertions.
  // ===========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_eload;
    osc_load && enh;
  endsequence

  a_enh_status: assert property (rd_st |-> hrdata[ST_BIT_ENH] == st_exp)
    else $error("enhanced status flag disagrees with the two enables");
  a_space_amp: assert property (s_eload ##0 (!txb && !(lb_v && lb)) |-> osc_amp == sh[IDX_SPACE_AMP])
    else $error("space amplitude not loaded");
  a_space_freq: assert property (s_eload ##0 !txb |-> osc_freq == sh[IDX_SPACE_FREQ])
    else $error("space frequency not loaded");
  a_mark_amp: assert property (s_eload ##0 (txb && !(lb_v && !lb)) |-> osc_amp == sh[IDX_MARK_AMP])
    else $error("mark amplitude not loaded");
  a_mark_freq: assert property (s_eload ##0 txb |-> osc_freq == sh[IDX_MARK_FREQ])
    else $error("mark frequency not loaded");
  a_s2m_gain: assert property (s_eload ##0 (txb && lb_v && !lb) |->
                               osc_amp == scl(sh[IDX_MARK_AMP], sh[IDX_S2M_GAIN]))
    else $error("space to mark gain not applied");
  a_m2s_gain: assert property (s_eload ##0 (!txb && lb_v && lb) |->
                               osc_amp == scl(sh[IDX_SPACE_AMP], sh[IDX_M2S_GAIN]))
    else $error("mark to space gain not applied");
  a_normal_reload: assert property ($rose(osc_load) && !enh |->
                                    osc_amp == sh[IDX_TONE_AMP] && osc_freq == sh[IDX_TONE_FREQ])
    else $error("normal coefficients not loaded");
endmodule

`default_nettype wire

// *** bench/fcs_sequencer_test.sv ***
// Self-checking bench for the shift-keying sequencer.
// Assumes the bench is the only AHB-Lite master and the sample tick is fixed inside the design.
`default_nettype none

module fcs_sequencer_test;
  timeunit 1ns;
  timeprecision 100ps;
  import fcs_pkg::*;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  wire logic   hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [15:0] osc_amp;
  logic [15:0] osc_freq;
  logic        osc_load;
  logic        osc_running;
  int          bad_count = 0;
  int          n_checks = 0;
  int          cyc = 0;

  assign hready = hreadyout;

  fcs_sequencer i_fcs_sequencer (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .osc_amp(osc_amp), .osc_freq(osc_freq), .osc_load(osc_load),
    .osc_running(osc_running)
  );

  always #12.5 clk = ~clk;

  // ===========================================================================
  // Shared tasks.
  // ===========================================================================
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Loads take thousands of cycles, so the ceiling leaves room for two dozen of them.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      $display("[ERR] %0t timeout", $time);
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic [7:0] idx, input logic wr, input logic [2:0] sz,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize  <= sz;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    bus(idx, 1'b1, HSIZE_WORD, d, r);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    bus(idx, 1'b0, HSIZE_WORD, 32'h0, r);
    chk(r, exp);
  endtask

  task automatic wait_load(input logic [15:0] amp, input logic [15:0] freq);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (osc_load !== 1'b1 && n < 6000);
    chk({31'h0, osc_load}, 32'h1);
    chk({osc_amp, osc_freq}, {amp, freq});
  endtask

  // ===========================================================================
  // Scenarios.
  // ===========================================================================
  task automatic t_regs();
    logic [31:0] r;
    wr(IDX_SPACE_AMP, 32'hABCD_F000);
    wr(IDX_SPACE_FREQ, 32'h0000_0700);
    wr(IDX_MARK_AMP, 32'h0000_1234);
    wr(IDX_MARK_FREQ, 32'h0000_0900);
    wr(IDX_S2M_GAIN, 32'h0000_6000);
    wr(IDX_M2S_GAIN, 32'h0000_2000);
    wr(IDX_TONE_AMP, 32'h0000_0444);
    wr(IDX_TONE_FREQ, 32'h0000_0333);
    wr(IDX_ACT_TIMER, 32'h0000_0001);
    rd(IDX_SPACE_AMP, 32'h0000_F000);
    bus(IDX_SPACE_AMP, 1'b1, 3'b000, 32'h0000_0011, r);
    rd(IDX_SPACE_AMP, 32'h0000_F000);
    wr(8'h44, 32'h0000_5555);
    rd(8'h44, 32'h0000_0000);
  endtask

  task automatic t_single_enable();
    wr(IDX_TX_BIT, 32'h1);
    wr(IDX_RELOAD_CTRL, 32'h01);
    wait_load(16'h0444, 16'h0333);
    chk({31'h0, osc_running}, 32'h1);
    wr(IDX_MODE_CTRL, 32'h40);
    // A period of one keeps the timer count at one, and it shows in the upper half.
    rd(IDX_STATUS, 32'h0001_0001);
    wait_load(16'h0444, 16'h0333);
    wr(IDX_MODE_CTRL, 32'h00);
    wr(IDX_RELOAD_CTRL, 32'h41);
    wait_load(16'h0444, 16'h0333);
  endtask

  task automatic t_enhanced();
    logic [31:0] r;
    wr(IDX_TX_BIT, 32'h0);
    wr(IDX_MODE_CTRL, 32'h40);
    bus(IDX_STATUS, 1'b0, HSIZE_WORD, 32'h0, r);
    chk({31'h0, r[ST_BIT_ENH]}, 32'h1);
    wait_load(16'hF000, 16'h0700);
    wr(IDX_TX_BIT, 32'h1);
    wait_load(16'h1B4E, 16'h0900);
    wait_load(16'h1234, 16'h0900);
    wr(IDX_TX_BIT, 32'h0);
    wait_load(16'hF800, 16'h0700);
  endtask

  // With the oscillator off the timer must not reload anything.
  task automatic t_off();
    int n;
    wr(IDX_RELOAD_CTRL, 32'h40);
    n = 0;
    repeat (6000) begin
      @(posedge clk);
      #1;
      if (osc_load === 1'b1) n++;
    end
    chk(n, 0);
    chk({31'h0, osc_running}, 32'h0);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk({hreadyout, osc_load, osc_running}, 32'h4);
    t_regs();
    t_single_enable();
    t_enhanced();
    t_off();
    report_and_stop();
  end
endmodule

bind fcs_sequencer fcs_sequencer_asserts i_fcs_sequencer_asserts (
  .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .osc_amp(osc_amp), .osc_freq(osc_freq), .osc_load(osc_load),
  .osc_running(osc_running)
);

`default_nettype wire
